/* File: hdl/pin_function_select_mux.sv */
// Pin-shared function select registers and pad multiplexer for ports A, B and C
//
// Summary of operation
// (R01) Source select 0 low field routes serial data input from A2, C5, A5 or D3.
// (R02) Source select 1 low field takes ext interrupt 0 from B0 on 01, else A1.
// (R03) Bits 7 to 4 of source select 1 ignore writes and read zero.
// (R04) A3 gives general I/O, chip select, timer output or analog channel 1.
// (R05) A2 carries the shared serial data function on 01, else general I/O.
// (R06) A1 gives general I/O with interrupt 0, serial clock, inverted timer, analog 0.
// (R07) A0 carries transmit or SPI data out on 01, else general I/O.
// (R08) A7 gives I/O with interrupt 1, segment 2, transmit data, analog 6.
// (R09) A6 gives I/O with timer clock, segment 1, serial clock, analog 5.
// (R10) A5 gives I/O with timer capture, segment 0, serial data, analog 4.
// (R11) A4 becomes the reference voltage pin on 10, else general I/O.
// (R12) B0 gives I/O with interrupt 0, segment 3, chip select, analog 7.
// (R13) B2 and B1 become segments 5 and 4 on 01, else general I/O.
// (R14) B6 gives general I/O, timer output on 01, analog channel 2 on 11.
// (R15) B5 and B4 become segments 8 and 7 on 01, else general I/O.
// (R16) C3 to C0 become LCD common outputs 3 to 0 on 01.
// (R17) C7 becomes chip select on 01, else I/O with standard timer clock.
// (R18) C6 becomes the serial clock on 01, else general I/O.
// (R19) C5 carries the shared serial data function on 01, else general I/O.
// (R20) C4 carries transmit or SPI data out on 01, else general I/O.
// (R21) Software sets a pin as input when using it for a digital input.
// (R22) Source select 1 bits 3:2 take ext interrupt 1 from A7 on 01, else A4.
// (R23) Codes that fall back to general I/O leave the pin to port logic alone.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module pin_function_select_mux
  import pin_mux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [7:0] gpio_a_out,
  input wire logic [7:0] gpio_a_oe_n,
  input wire logic [7:0] gpio_b_out,
  input wire logic [7:0] gpio_b_oe_n,
  input wire logic [7:0] gpio_c_out,
  input wire logic [7:0] gpio_c_oe_n,
  output logic [7:0] gpio_a_in,
  output logic [7:0] gpio_b_in,
  output logic [7:0] gpio_c_in,
  input wire logic [7:0] pad_a_in,
  input wire logic [7:0] pad_b_in,
  input wire logic [7:0] pad_c_in,
  input wire logic pad_d3_in,
  output logic [7:0] pad_a_out,
  output logic [7:0] pad_a_oe_n,
  output logic [7:0] pad_b_out,
  output logic [7:0] pad_b_oe_n,
  output logic [7:0] pad_c_out,
  output logic [7:0] pad_c_oe_n,
  input wire logic txd_sdo_out,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sdata_out,
  input wire logic sdata_oe_n,
  input wire logic scs_out,
  input wire logic scs_oe_n,
  input wire logic ptp_out,
  input wire logic periodic_timer_output_inverted_out,
  input wire logic [8:0] lcd_seg,
  input wire logic [3:0] lcd_com,
  output logic sdata_in,
  output logic ext_ext_interrupt_0_in,
  output logic ext_ext_interrupt_1_in,
  output logic periodic_timer_clock_in_in,
  output logic periodic_timer_capture_in_in,
  output logic std_timer_capture_input_in,
  output logic std_timer_clock_in_in,
  output logic [7:0] analog_en,
  output logic vref_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Select registers

  logic [DATA_W-1:0] sel_reg [0:NUM_REGS-1];
  logic addr_hit;
  logic [2:0] addr_idx;

  assign addr_hit = (reg_addr < ADDR_W'(NUM_REGS));
  assign addr_idx = reg_addr[2:0];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        sel_reg[i] <= SEL_RESET;
      end
    end else if (reg_wr && addr_hit) begin
      if (reg_addr == ADDR_INPUT_ROUTE_SELECT_1) begin
        sel_reg[addr_idx] <= reg_wdata & INPUT_ROUTE_1_MASK; // see (R03)
      end else begin
        sel_reg[addr_idx] <= reg_wdata & FULL_MASK;
      end
    end
  end

  // Unmapped offsets read as zero so software can probe safely
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= SEL_RESET;
    end else if (reg_rd && addr_hit) begin
      reg_rdata <= sel_reg[addr_idx];
    end else begin
      reg_rdata <= SEL_RESET;
    end
  end

  logic [15:0] pa_sel;
  logic [15:0] pb_sel;
  logic [15:0] pc_sel;
  logic [7:0] src0;
  logic [7:0] src1;

  assign pa_sel = {sel_reg[ADDR_PORT_A_FUNCTION_SELECT_HI[2:0]],
                   sel_reg[ADDR_PORT_A_FUNCTION_SELECT_LO[2:0]]};
  assign pb_sel = {sel_reg[ADDR_PORT_B_FUNCTION_SELECT_HI[2:0]],
                   sel_reg[ADDR_PORT_B_FUNCTION_SELECT_LO[2:0]]};
  assign pc_sel = {sel_reg[ADDR_PORT_C_FUNCTION_SELECT_HI[2:0]],
                   sel_reg[ADDR_PORT_C_FUNCTION_SELECT_LO[2:0]]};
  assign src0 = sel_reg[ADDR_INPUT_ROUTE_SELECT_0[2:0]];
  assign src1 = sel_reg[ADDR_INPUT_ROUTE_SELECT_1[2:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchronisers

  logic [7:0] a_meta_reg;
  logic [7:0] b_meta_reg;
  logic [7:0] c_meta_reg;
  logic d3_meta_reg;
  logic [7:0] a_sync_reg;
  logic [7:0] b_sync_reg;
  logic [7:0] c_sync_reg;
  logic d3_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      a_meta_reg <= 8'h00;
      b_meta_reg <= 8'h00;
      c_meta_reg <= 8'h00;
      d3_meta_reg <= 1'b0;
      a_sync_reg <= 8'h00;
      b_sync_reg <= 8'h00;
      c_sync_reg <= 8'h00;
      d3_sync_reg <= 1'b0;
    end else begin
      a_meta_reg <= pad_a_in;
      b_meta_reg <= pad_b_in;
      c_meta_reg <= pad_c_in;
      d3_meta_reg <= pad_d3_in;
      a_sync_reg <= a_meta_reg;
      b_sync_reg <= b_meta_reg;
      c_sync_reg <= c_meta_reg;
      d3_sync_reg <= d3_meta_reg;
    end
  end

  assign gpio_a_in = a_sync_reg;
  assign gpio_b_in = b_sync_reg;
  assign gpio_c_in = c_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input routing
  // Digital inputs share the general I/O code; the pin must also be set as
  // an input by software, this block does not force the direction (R21)

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sdata_in <= 1'b0;
      ext_ext_interrupt_0_in <= 1'b0;
      ext_ext_interrupt_1_in <= 1'b0;
      periodic_timer_clock_in_in <= 1'b0;
      periodic_timer_capture_in_in <= 1'b0;
      std_timer_capture_input_in <= 1'b0;
      std_timer_clock_in_in <= 1'b0;
    end else begin
      unique case (src0[FLD_SDATA_SRC +: FIELD_W]) // see (R01)
        FN_PRIMARY: sdata_in <= a_sync_reg[2];
        FN_ALT1: sdata_in <= c_sync_reg[5];
        FN_ALT2: sdata_in <= a_sync_reg[5];
        FN_ALT3: sdata_in <= d3_sync_reg;
      endcase
      if (src1[FLD_EXT_INTERRUPT_0_SRC +: FIELD_W] == FN_ALT1) begin // see (R02)
        ext_ext_interrupt_0_in <= b_sync_reg[0];
      end else begin
        ext_ext_interrupt_0_in <= a_sync_reg[1];
      end
      if (src1[FLD_EXT_INTERRUPT_1_SRC +: FIELD_W] == FN_ALT1) begin // see (R22)
        ext_ext_interrupt_1_in <= a_sync_reg[7];
      end else begin
        ext_ext_interrupt_1_in <= a_sync_reg[4];
      end
      periodic_timer_clock_in_in <= a_sync_reg[6]; // see (R09)
      periodic_timer_capture_in_in <= a_sync_reg[5]; // see (R10)
      std_timer_capture_input_in <= a_sync_reg[4]; // see (R11)
      std_timer_clock_in_in <= c_sync_reg[7]; // see (R17)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad output multiplexer
  // Registered so pads never see a glitch while a select field is rewritten

  logic [7:0] a_out_next;
  logic [7:0] a_oe_n_next;
  logic [7:0] b_out_next;
  logic [7:0] b_oe_n_next;
  logic [7:0] c_out_next;
  logic [7:0] c_oe_n_next;
  logic [7:0] ana_next;
  logic vref_next;

  always_comb begin
    // Every fallback code leaves port data and direction in charge
    a_out_next = gpio_a_out; // see (R23)
    a_oe_n_next = gpio_a_oe_n;
    b_out_next = gpio_b_out;
    b_oe_n_next = gpio_b_oe_n;
    c_out_next = gpio_c_out;
    c_oe_n_next = gpio_c_oe_n;
    ana_next = 8'h00;
    vref_next = 1'b0;
    // Port A
    if (pa_sel[FLD_PIN0 +: FIELD_W] == FN_ALT1) begin // see (R07)
      a_out_next[0] = txd_sdo_out;
      a_oe_n_next[0] = 1'b0;
    end
    unique case (pa_sel[FLD_PIN1 +: FIELD_W]) // see (R06)
      FN_PRIMARY: ;
      FN_ALT1: begin
        a_out_next[1] = sck_out;
        a_oe_n_next[1] = sck_oe_n;
      end
      FN_ALT2: begin
        a_out_next[1] = periodic_timer_output_inverted_out;
        a_oe_n_next[1] = 1'b0;
      end
      FN_ALT3: begin
        a_out_next[1] = 1'b0;
        a_oe_n_next[1] = 1'b1;
        ana_next[0] = 1'b1;
      end
    endcase
    if (pa_sel[FLD_PIN2 +: FIELD_W] == FN_ALT1) begin // see (R05)
      a_out_next[2] = sdata_out;
      a_oe_n_next[2] = sdata_oe_n;
    end
    unique case (pa_sel[FLD_PIN3 +: FIELD_W]) // see (R04)
      FN_PRIMARY: ;
      FN_ALT1: begin
        a_out_next[3] = scs_out;
        a_oe_n_next[3] = scs_oe_n;
      end
      FN_ALT2: begin
        a_out_next[3] = ptp_out;
        a_oe_n_next[3] = 1'b0;
      end
      FN_ALT3: begin
        a_out_next[3] = 1'b0;
        a_oe_n_next[3] = 1'b1;
        ana_next[1] = 1'b1;
      end
    endcase
    if (pa_sel[FLD_PIN4 +: FIELD_W] == FN_ALT2) begin // see (R11)
      a_out_next[4] = 1'b0;
      a_oe_n_next[4] = 1'b1;
      vref_next = 1'b1;
    end
    unique case (pa_sel[FLD_PIN5 +: FIELD_W]) // see (R10)
      FN_PRIMARY: ;
      FN_ALT1: begin
        a_out_next[5] = lcd_seg[0];
        a_oe_n_next[5] = 1'b0;
      end
      FN_ALT2: begin
        a_out_next[5] = sdata_out;
        a_oe_n_next[5] = sdata_oe_n;
      end
      FN_ALT3: begin
        a_out_next[5] = 1'b0;
        a_oe_n_next[5] = 1'b1;
        ana_next[4] = 1'b1;
      end
    endcase
    unique case (pa_sel[FLD_PIN6 +: FIELD_W]) // see (R09)
      FN_PRIMARY: ;
      FN_ALT1: begin
        a_out_next[6] = lcd_seg[1];
        a_oe_n_next[6] = 1'b0;
      end
      FN_ALT2: begin
        a_out_next[6] = sck_out;
        a_oe_n_next[6] = sck_oe_n;
      end
      FN_ALT3: begin
        a_out_next[6] = 1'b0;
        a_oe_n_next[6] = 1'b1;
        ana_next[5] = 1'b1;
      end
    endcase
    unique case (pa_sel[FLD_PIN7 +: FIELD_W]) // see (R08)
      FN_PRIMARY: ;
      FN_ALT1: begin
        a_out_next[7] = lcd_seg[2];
        a_oe_n_next[7] = 1'b0;
      end
      FN_ALT2: begin
        a_out_next[7] = txd_sdo_out;
        a_oe_n_next[7] = 1'b0;
      end
      FN_ALT3: begin
        a_out_next[7] = 1'b0;
        a_oe_n_next[7] = 1'b1;
        ana_next[6] = 1'b1;
      end
    endcase
    // Port B
    unique case (pb_sel[FLD_PIN0 +: FIELD_W]) // see (R12)
      FN_PRIMARY: ;
      FN_ALT1: begin
        b_out_next[0] = lcd_seg[3];
        b_oe_n_next[0] = 1'b0;
      end
      FN_ALT2: begin
        b_out_next[0] = scs_out;
        b_oe_n_next[0] = scs_oe_n;
      end
      FN_ALT3: begin
        b_out_next[0] = 1'b0;
        b_oe_n_next[0] = 1'b1;
        ana_next[7] = 1'b1;
      end
    endcase
    if (pb_sel[FLD_PIN1 +: FIELD_W] == FN_ALT1) begin // see (R13)
      b_out_next[1] = lcd_seg[4];
      b_oe_n_next[1] = 1'b0;
    end
    if (pb_sel[FLD_PIN2 +: FIELD_W] == FN_ALT1) begin // see (R13)
      b_out_next[2] = lcd_seg[5];
      b_oe_n_next[2] = 1'b0;
    end
    if (pb_sel[FLD_PIN3 +: FIELD_W] == FN_ALT1) begin
      b_out_next[3] = lcd_seg[6];
      b_oe_n_next[3] = 1'b0;
    end
    if (pb_sel[FLD_PIN4 +: FIELD_W] == FN_ALT1) begin // see (R15)
      b_out_next[4] = lcd_seg[7];
      b_oe_n_next[4] = 1'b0;
    end
    if (pb_sel[FLD_PIN5 +: FIELD_W] == FN_ALT1) begin // see (R15)
      b_out_next[5] = lcd_seg[8];
      b_oe_n_next[5] = 1'b0;
    end
    if (pb_sel[FLD_PIN6 +: FIELD_W] == FN_ALT1) begin // see (R14)
      b_out_next[6] = ptp_out;
      b_oe_n_next[6] = 1'b0;
    end else if (pb_sel[FLD_PIN6 +: FIELD_W] == FN_ALT3) begin // see (R14)
      b_out_next[6] = 1'b0;
      b_oe_n_next[6] = 1'b1;
      ana_next[2] = 1'b1;
    end
    if (pb_sel[FLD_PIN7 +: FIELD_W] == FN_ALT1) begin
      b_out_next[7] = txd_sdo_out;
      b_oe_n_next[7] = 1'b0;
    end else if (pb_sel[FLD_PIN7 +: FIELD_W] == FN_ALT3) begin
      b_out_next[7] = 1'b0;
      b_oe_n_next[7] = 1'b1;
      ana_next[3] = 1'b1;
    end
    // Port C: commons on the low nibble
    for (int n = 0; n < 4; n++) begin
      if (pc_sel[2*n +: FIELD_W] == FN_ALT1) begin // see (R16)
        c_out_next[n] = lcd_com[n];
        c_oe_n_next[n] = 1'b0;
      end
    end
    if (pc_sel[FLD_PIN4 +: FIELD_W] == FN_ALT1) begin // see (R20)
      c_out_next[4] = txd_sdo_out;
      c_oe_n_next[4] = 1'b0;
    end
    if (pc_sel[FLD_PIN5 +: FIELD_W] == FN_ALT1) begin // see (R19)
      c_out_next[5] = sdata_out;
      c_oe_n_next[5] = sdata_oe_n;
    end
    if (pc_sel[FLD_PIN6 +: FIELD_W] == FN_ALT1) begin // see (R18)
      c_out_next[6] = sck_out;
      c_oe_n_next[6] = sck_oe_n;
    end
    if (pc_sel[FLD_PIN7 +: FIELD_W] == FN_ALT1) begin // see (R17)
      c_out_next[7] = scs_out;
      c_oe_n_next[7] = scs_oe_n;
    end
  end

  // Pads released (not driven) during reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pad_a_out <= 8'h00;
      pad_a_oe_n <= 8'hff;
      pad_b_out <= 8'h00;
      pad_b_oe_n <= 8'hff;
      pad_c_out <= 8'h00;
      pad_c_oe_n <= 8'hff;
      analog_en <= 8'h00;
      vref_en <= 1'b0;
    end else begin
      pad_a_out <= a_out_next;
      pad_a_oe_n <= a_oe_n_next;
      pad_b_out <= b_out_next;
      pad_b_oe_n <= b_oe_n_next;
      pad_c_out <= c_out_next;
      pad_c_oe_n <= c_oe_n_next;
      analog_en <= ana_next;
      vref_en <= vref_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  route_read_upper_a: assert property ( // see (R03)
    reg_rd && reg_addr == ADDR_INPUT_ROUTE_SELECT_1 |=> reg_rdata[7:4] == 4'h0)
    else $error("route select 1 upper bits not zero");

  sdata_source_a: assert property ( // see (R01)
    src0[FLD_SDATA_SRC +: FIELD_W] == FN_ALT3 |=> sdata_in == $past(d3_sync_reg))
    else $error("serial data not routed from D3");

  sdata_pin_a: assert property ( // see (R01)
    src0[FLD_SDATA_SRC +: FIELD_W] == FN_ALT1 ##1 $stable(c_sync_reg[5])
      |-> sdata_in == c_sync_reg[5])
    else $error("serial data not routed from C5");

  ext_interrupt_0_source_a: assert property ( // see (R02)
    src1[FLD_EXT_INTERRUPT_0_SRC +: FIELD_W] != FN_ALT1 |=> ext_ext_interrupt_0_in == $past(a_sync_reg[1]))
    else $error("interrupt 0 not taken from A1");

  ext_interrupt_1_source_a: assert property ( // see (R22)
    src1[FLD_EXT_INTERRUPT_1_SRC +: FIELD_W] == FN_ALT1 |=> ext_ext_interrupt_1_in == $past(a_sync_reg[7]))
    else $error("interrupt 1 not taken from A7");

  a3_timer_a: assert property ( // see (R04)
    pa_sel[FLD_PIN3 +: FIELD_W] == FN_ALT2 |=> pad_a_out[3] == $past(ptp_out)
      && !pad_a_oe_n[3])
    else $error("A3 not driving timer output");

  a2_fallback_a: assert property ( // see (R05)
    pa_sel[FLD_PIN2 +: FIELD_W] != FN_ALT1 |=> pad_a_out[2] == $past(gpio_a_out[2])
      && pad_a_oe_n[2] == $past(gpio_a_oe_n[2]))
    else $error("A2 not left to port logic");

  a1_analog_a: assert property ( // see (R06)
    pa_sel[FLD_PIN1 +: FIELD_W] == FN_ALT3 |=> analog_en[0] && pad_a_oe_n[1])
    else $error("A1 analog channel not enabled");

  a0_transmit_a: assert property ( // see (R07)
    pa_sel[FLD_PIN0 +: FIELD_W] == FN_ALT1 |=> pad_a_out[0] == $past(txd_sdo_out))
    else $error("A0 not carrying transmit data");

  a4_vref_a: assert property ( // see (R11)
    vref_en |-> $past(pa_sel[FLD_PIN4 +: FIELD_W]) == FN_ALT2)
    else $error("reference pin enabled without its code");

  b0_select_a: assert property ( // see (R12)
    pb_sel[FLD_PIN0 +: FIELD_W] == FN_ALT2 |=> pad_b_out[0] == $past(scs_out))
    else $error("B0 not carrying chip select");

  c_common_a: assert property ( // see (R16)
    pc_sel[FLD_PIN3 +: FIELD_W] == FN_ALT1 |=> pad_c_out[3] == $past(lcd_com[3])
      && !pad_c_oe_n[3])
    else $error("C3 not carrying common 3");

  analog_only_a: assert property ( // see (R23)
    pb_sel[FLD_PIN6 +: FIELD_W] == FN_ALT2 |=> !analog_en[2]
      && pad_b_out[6] == $past(gpio_b_out[6]))
    else $error("B6 reserved code not general I/O");

  seg_path_c: cover property (
    reg_wr && reg_addr == ADDR_PORT_B_FUNCTION_SELECT_HI ##1 pb_sel[FLD_PIN5 +: FIELD_W] == FN_ALT1);

  route_change_c: cover property (
    src1[FLD_EXT_INTERRUPT_0_SRC +: FIELD_W] == FN_ALT1 ##1 ext_ext_interrupt_0_in ##1 !ext_ext_interrupt_0_in);

  analog_many_c: cover property (analog_en[0] && analog_en[1] && vref_en);

endmodule

/* File: hdl/pin_mux_pkg.sv */
// Constants for the pin-shared function select multiplexer
package pin_mux_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  localparam int FIELD_W = 2;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_INPUT_ROUTE_SELECT_0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_ROUTE_SELECT_1 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PORT_A_FUNCTION_SELECT_LO = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PORT_A_FUNCTION_SELECT_HI = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_PORT_B_FUNCTION_SELECT_LO = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_PORT_B_FUNCTION_SELECT_HI = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PORT_C_FUNCTION_SELECT_LO = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PORT_C_FUNCTION_SELECT_HI = 4'h7;

  // Reset value and implemented bits
  localparam logic [DATA_W-1:0] SEL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INPUT_ROUTE_1_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] FULL_MASK = 8'hff;

  // Field positions of pin n inside the 16-bit {hi, lo} select pair
  localparam int FLD_PIN0 = 0;
  localparam int FLD_PIN1 = 2;
  localparam int FLD_PIN2 = 4;
  localparam int FLD_PIN3 = 6;
  localparam int FLD_PIN4 = 8;
  localparam int FLD_PIN5 = 10;
  localparam int FLD_PIN6 = 12;
  localparam int FLD_PIN7 = 14;

  // Input route fields
  localparam int FLD_SDATA_SRC = 0;
  localparam int FLD_EXT_INTERRUPT_0_SRC = 0;
  localparam int FLD_EXT_INTERRUPT_1_SRC = 2;

  // Selection codes
  localparam logic [FIELD_W-1:0] FN_PRIMARY = 2'h0;
  localparam logic [FIELD_W-1:0] FN_ALT1 = 2'h1;
  localparam logic [FIELD_W-1:0] FN_ALT2 = 2'h2;
  localparam logic [FIELD_W-1:0] FN_ALT3 = 2'h3;

endpackage

/* File: bench/pin_function_select_mux_tb_top.sv */
// Self-checking testbench for the pin-shared function select multiplexer
`timescale 1ns/1ns
module pin_function_select_mux_tb_top;
  import pin_mux_pkg::*;

  logic sys_clk = 1'b0;
  logic resetn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic [7:0] gpio_a_out, gpio_a_oe_n, gpio_b_out, gpio_b_oe_n, gpio_c_out, gpio_c_oe_n;
  logic [7:0] gpio_a_in, gpio_b_in, gpio_c_in, pad_a_in, pad_b_in, pad_c_in;
  logic pad_d3_in;
  logic [7:0] pad_a_out, pad_a_oe_n, pad_b_out, pad_b_oe_n, pad_c_out, pad_c_oe_n;
  logic txd_sdo_out, sck_out, sck_oe_n, sdata_out, sdata_oe_n, scs_out, scs_oe_n;
  logic ptp_out, periodic_timer_output_inverted_out;
  logic [8:0] lcd_seg;
  logic [3:0] lcd_com;
  logic sdata_in, ext_ext_interrupt_0_in, ext_ext_interrupt_1_in, periodic_timer_clock_in_in, periodic_timer_capture_in_in, std_timer_capture_input_in, std_timer_clock_in_in, vref_en;
  logic [7:0] analog_en;
  int errors = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Expected pad pictures, three codes per select register, offsets 2 to 7
  logic [7:0] pm_t [18] = '{8'h0f, 8'h0a, 8'h00, 8'he0, 8'he0, 8'h00,
    8'h0f, 8'h01, 8'h00, 8'hf0, 8'h00, 8'h00,
    8'h0f, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h00};
  logic [7:0] ap_t [18] = '{8'h00, 8'h00, 8'h0a, 8'h00, 8'h10, 8'he0,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ae_t [18] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h70,
    8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] sd_a [4] = '{8'h04, 8'h00, 8'h20, 8'h00};
  logic [7:0] sd_c [4] = '{8'h00, 8'h20, 8'h00, 8'h00};
  logic [3:0] addr;
  logic [7:0] data, sa;
  logic [7:0] m [3];
  logic [7:0] a [3];
  int p;

  pin_function_select_mux dut_u (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .gpio_a_out, .gpio_a_oe_n, .gpio_b_out, .gpio_b_oe_n, .gpio_c_out, .gpio_c_oe_n,
    .gpio_a_in, .gpio_b_in, .gpio_c_in, .pad_a_in, .pad_b_in, .pad_c_in, .pad_d3_in,
    .pad_a_out, .pad_a_oe_n, .pad_b_out, .pad_b_oe_n, .pad_c_out, .pad_c_oe_n,
    .txd_sdo_out, .sck_out, .sck_oe_n, .sdata_out, .sdata_oe_n, .scs_out, .scs_oe_n,
    .ptp_out, .periodic_timer_output_inverted_out, .lcd_seg, .lcd_com, .sdata_in, .ext_ext_interrupt_0_in, .ext_ext_interrupt_1_in,
    .periodic_timer_clock_in_in, .periodic_timer_capture_in_in, .std_timer_capture_input_in, .std_timer_clock_in_in, .analog_en, .vref_en
  );

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    {gpio_a_out, gpio_b_out, gpio_c_out} = 24'h000000;
    {gpio_a_oe_n, gpio_b_oe_n, gpio_c_oe_n} = 24'hffffff;
    {pad_a_in, pad_b_in, pad_c_in} = 24'h000000;
    pad_d3_in = 1'b0;
    {txd_sdo_out, sck_out, sdata_out, scs_out, ptp_out, periodic_timer_output_inverted_out} = 6'h3f;
    {sck_oe_n, sdata_oe_n, scs_oe_n} = 3'h0;
    lcd_seg = 9'h1ff;
    lcd_com = 4'hf;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(4'(i), 8'h00);
    wr(ADDR_INPUT_ROUTE_SELECT_1, 8'hff);
    rd(ADDR_INPUT_ROUTE_SELECT_1, 8'h0f);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    rd(ADDR_INPUT_ROUTE_SELECT_1, 8'h0f);
    wr(ADDR_INPUT_ROUTE_SELECT_1, 8'h00);
    // Pass 0: port logic releases and peripherals drive high; pass 1 the reverse
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      {gpio_a_out, gpio_b_out, gpio_c_out} <= s ? 24'hffffff : 24'h000000;
      {gpio_a_oe_n, gpio_b_oe_n, gpio_c_oe_n} <= s ? 24'h000000 : 24'hffffff;
      {txd_sdo_out, sck_out, sdata_out, scs_out, ptp_out, periodic_timer_output_inverted_out} <= s ? 6'h00 : 6'h3f;
      lcd_seg <= s ? 9'h000 : 9'h1ff;
      lcd_com <= s ? 4'h0 : 4'hf;
      for (int i = 0; i < 18; i++) begin
        addr = 4'(2 + i / 3);
        data = (i % 3 == 0) ? 8'h55 : ((i % 3 == 1) ? 8'haa : 8'hff);
        p = i / 6;
        wr(addr, data);
        @(posedge sys_clk);
        #1;
        for (int q = 0; q < 3; q++) begin
          m[q] = (q == p) ? pm_t[i] : 8'h00;
          a[q] = (q == p) ? ap_t[i] : 8'h00;
        end
        check(pad_a_out, s ? ~m[0] & ~a[0] : m[0]);
        check(pad_a_oe_n, s ? a[0] : ~m[0]);
        check(pad_b_out, s ? ~m[1] & ~a[1] : m[1]);
        check(pad_b_oe_n, s ? a[1] : ~m[1]);
        check(pad_c_out, s ? ~m[2] & ~a[2] : m[2]);
        check(pad_c_oe_n, s ? a[2] : ~m[2]);
        check(analog_en, ae_t[i]);
        check({7'h00, vref_en}, {7'h00, i == 4});
        rd(addr, data);
        wr(addr, 8'h00);
      end
    end
    // Input routing, with every port line set as input
    @(posedge sys_clk);
    {gpio_a_oe_n, gpio_b_oe_n, gpio_c_oe_n} <= 24'hffffff;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_INPUT_ROUTE_SELECT_0, 8'(k));
      wr(ADDR_INPUT_ROUTE_SELECT_1, 8'(k * 5));
      sa = sd_a[k] | ((k == 1) ? 8'h80 : 8'h12);
      for (int v = 0; v < 2; v++) begin
        @(posedge sys_clk);
        pad_a_in <= v ? ~sa : sa;
        pad_b_in <= ((k == 1) ? 8'h01 : 8'h00) ^ {8{v[0]}};
        pad_c_in <= sd_c[k] ^ {8{v[0]}};
        pad_d3_in <= (k == 3) ^ v[0];
        repeat (4) @(posedge sys_clk);
        #1;
        check({7'h00, sdata_in}, {7'h00, v == 0});
        check({7'h00, ext_ext_interrupt_0_in}, {7'h00, v == 0});
        check({7'h00, ext_ext_interrupt_1_in}, {7'h00, v == 0});
        check(gpio_a_in, pad_a_in);
        check(gpio_b_in, pad_b_in);
        check(gpio_c_in, pad_c_in);
        check({4'h0, periodic_timer_clock_in_in, periodic_timer_capture_in_in, std_timer_capture_input_in, std_timer_clock_in_in},
              {4'h0, pad_a_in[6], pad_a_in[5], pad_a_in[4], pad_c_in[7]});
      end
    end
    // A reset in mid-run clears the selections again
    wr(ADDR_PORT_A_FUNCTION_SELECT_LO, 8'h55);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd(ADDR_PORT_A_FUNCTION_SELECT_LO, 8'h00);
    rd(ADDR_INPUT_ROUTE_SELECT_1, 8'h00);
    check(pad_a_oe_n, 8'hff);
    print_verdict;
  end

  // Whole run needs well under two thousand cycles; a hang stops here
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict;
  end

endmodule
